//--- inc/tlbmr_defines.svh
// Register numbers, field layouts and page shift codes of the translation register set
`ifndef TLBMR_DEFINES_SVH
`define TLBMR_DEFINES_SVH
`define TLBMR_REG_SET        5'h00
`define TLBMR_REG_PHYS       5'h02
`define TLBMR_REG_USER_PTE_BASE      5'h04
`define TLBMR_REG_SHIFT      5'h05
`define TLBMR_REG_FAULT_VIRTUAL_ADDRESS      5'h08
`define TLBMR_REG_TAG        5'h0a
`define TLBMR_REG_KERNEL_PRIVATE_PTE_BASE      5'h14
`define TLBMR_REG_KERNEL_GLOBAL_PTE_BASE      5'h15
`define TLBMR_REG_WIRED      5'h18
`define TLBMR_PHYS_MASK      64'h0000_00ff_ffff_ff80
`define TLBMR_PHYS_C_LSB     9
`define TLBMR_TAG_MASK       64'hc000_ffff_fff8_0ff0
`define TLBMR_TAG_R_LSB      62
`define TLBMR_TAG_VPN_LSB    19
`define TLBMR_TAG_VPN_MSB    47
`define TLBMR_TAG_ADDRESS_SPACE_ID_LSB   4
`define TLBMR_BASE_MASK      64'hffff_ffff_ffff_f000
`define TLBMR_SHIFT_MASK     64'h0000_0000_0000_001f
`define TLBMR_ZERO_LSB       19
`define TLBMR_WIRED_STRIDE   16
`define TLBMR_WIRED_VBIT     15
`define TLBMR_COH_UNC_PROC   3'h0
`define TLBMR_COH_UNC_SEQ    3'h2
`define TLBMR_COH_NONCOH     3'h3
`define TLBMR_COH_EXCL       3'h4
`define TLBMR_COH_EXCL_WR    3'h5
`define TLBMR_SA_4K          5'h0c
`define TLBMR_SA_8K          5'h0d
`define TLBMR_SA_16K         5'h0e
`define TLBMR_SA_64K         5'h10
`define TLBMR_SA_1M          5'h14
`define TLBMR_SA_4M          5'h16
`define TLBMR_SA_16M         5'h18
`define TLBMR_LFSR_SEED      8'h01
`define TLBMR_LFSR_TAPS      8'hb8
`endif

//--- inc/tlbmr_pkg.sv
// Types shared by the translation register set and its users
package tlbmr_pkg;
  typedef enum logic [1:0] {EXC_REFILL, EXC_INVALID, EXC_MODIFIED, EXC_ADDR_ERR} tlbmr_exc_e;
  typedef enum logic [2:0] {PG_4K, PG_8K, PG_16K, PG_64K, PG_1M, PG_4M, PG_16M} tlbmr_psize_e;
  typedef struct packed {
    logic         valid;
    tlbmr_exc_e   kind;
    logic [63:0]  va;
    tlbmr_psize_e psize;
    logic [1:0]   match_set;
  } tlbmr_exc_s;
  typedef struct packed {
    logic        to;
    logic        from;
    logic        narrow;
    logic [4:0]  num;
    logic [63:0] wdata;
  } tlbmr_move_s;
  typedef struct packed {
    logic        load;
    logic [63:0] phys;
    logic [63:0] tag;
  } tlbmr_rd_s;
endpackage

//--- hw/tlbmr_regs.sv
// Translation buffer management register set with refill set selection
//
// Overview of operation
// RULE_01: Physical entry holds frame number, coherence, dirty and valid; software read-write.
// RULE_02: Coherence codes 0,2,3,4,5 are legal; 1,6,7 are reserved.
// RULE_03: Unused field bits accept any write but always read back zero.
// RULE_04: Virtual tag carries two-bit region: 00 user, 01 kernel private, 11 kernel global.
// RULE_05: Translation exceptions load tag page number from address bits 47:19 and region.
// RULE_06: Page number bits 23:19 are individually forced to zero by page size.
// RULE_07: Translation exceptions leave the tag's address space identifier unchanged.
// RULE_08: Tag address space identifier takes part in translation matching.
// RULE_09: Address bits 18:12 are held neither in page number nor in entries.
// RULE_10: Three read-write page table bases of equal layout for the three regions.
// RULE_11: Shift amount is read-only and reports shift of most recent failed translation.
// RULE_12: Shift codes: 4K 12, 8K 13, 16K 14, 64K 16, 1M 20, 4M 22, 16M 24.
// RULE_13: Software pins at most four entries, each in a different congruence class.
// RULE_14: Buffer is three-way set associative; only set 0 may be pinned.
// RULE_15: Each pinned index has its own valid flag; only valid ones are matched.
// RULE_16: Refill miss matching a pinned class picks set 1..2, otherwise set 0..2.
// RULE_17: Virtual address register holds a full 64-bit address; software read-write.
// RULE_18: Refill, invalid, modified and address error exceptions load the virtual address.
// RULE_19: Virtual address register selects the entry for entry and cache tag instructions.
// RULE_20: Registers need no defined reset value; software must write before use.
// RULE_21: Invalid and modified exceptions write the matching set into set select.
// RULE_22: Only doubleword control moves access these registers; narrow moves are ignored.
// RULE_23: Random set comes from a free-running counter advancing every cycle; the code uses an 8-bit LFSR instead.
`timescale 1ns/1ps
`default_nettype none
`include "tlbmr_defines.svh"

module tlbmr_regs #(
  parameter int IDX_W = 7
) (
  input  wire logic                clk,
  input  wire logic                nrst,
  input  wire tlbmr_pkg::tlbmr_move_s move_req,
  input  wire tlbmr_pkg::tlbmr_exc_s  exc_in,
  input  wire tlbmr_pkg::tlbmr_rd_s   entry_rd,
  output logic [63:0]              move_rdata,
  output logic                     move_rvalid,
  output logic [63:0]              phys_entry_out,
  output logic [63:0]              virtual_tag_out,
  output logic [7:0]               address_space_id,
  output logic [63:0]              entry_select_addr,
  output logic [1:0]               set_select,
  output logic                     coh_legal,
  output logic                     coh_cacheable
);
  import tlbmr_pkg::*;

  logic [63:0] phys_reg;
  logic [63:0] tag_reg;
  logic [63:0] user_pte_base_reg;
  logic [63:0] kernel_private_pte_base_reg;
  logic [63:0] kernel_global_pte_base_reg;
  logic [63:0] fault_virtual_address_reg;
  logic [63:0] wired_reg;
  logic [4:0]  shift_reg;
  logic [1:0]  set_reg;
  logic [7:0]  lfsr_reg;
  logic [63:0] rdata_reg;
  logic        rvalid_reg;

  logic        wr_ok;
  logic        exc_xlate;
  logic [4:0]  exc_shift;
  logic [63:0] va_shifted;
  logic [IDX_W-1:0] miss_class;
  logic [3:0]  wired_hit;
  logic [4:0]  vpn_low_keep;
  logic [63:0] tag_from_exc;
  logic [1:0]  rand_any;
  logic [1:0]  rand_upper;
  logic [1:0]  refill_set;
  logic [63:0] rdata_next;

  // Narrow moves never write
  // RULE_22: doubleword only
  assign wr_ok = move_req.to && !move_req.narrow;

  // Address errors update only the virtual address register
  assign exc_xlate = exc_in.valid && (exc_in.kind != EXC_ADDR_ERR);

  // RULE_12: page shift codes
  always_comb begin
    case (exc_in.psize)
      PG_4K:   exc_shift = `TLBMR_SA_4K;
      PG_8K:   exc_shift = `TLBMR_SA_8K;
      PG_16K:  exc_shift = `TLBMR_SA_16K;
      PG_64K:  exc_shift = `TLBMR_SA_64K;
      PG_1M:   exc_shift = `TLBMR_SA_1M;
      PG_4M:   exc_shift = `TLBMR_SA_4M;
      PG_16M:  exc_shift = `TLBMR_SA_16M;
      default: exc_shift = `TLBMR_SA_4K;
    endcase
  end

  // Congruence class sits just above the page offset for every size
  assign va_shifted = exc_in.va >> exc_shift;
  assign miss_class = va_shifted[IDX_W-1:0];

  genvar gi;
  generate
    for (gi = 0; gi < 4; gi++) begin : g_wired
      // RULE_15: valid gated match
      assign wired_hit[gi] = wired_reg[gi*`TLBMR_WIRED_STRIDE + `TLBMR_WIRED_VBIT]
                             && (wired_reg[gi*`TLBMR_WIRED_STRIDE +: IDX_W] == miss_class);
    end
    for (gi = 0; gi < 5; gi++) begin : g_vpn_zero
      // RULE_06: per-bit page zeroing
      assign vpn_low_keep[gi] = (5'(`TLBMR_ZERO_LSB + gi) >= exc_shift);
    end
  endgenerate

  // RULE_05: page number and region load
  always_comb begin
    tag_from_exc = tag_reg;
    tag_from_exc[`TLBMR_TAG_VPN_MSB:`TLBMR_TAG_VPN_LSB] =
      exc_in.va[`TLBMR_TAG_VPN_MSB:`TLBMR_TAG_VPN_LSB];
    // RULE_06: bits 23 to 19 masked
    tag_from_exc[`TLBMR_TAG_VPN_LSB +: 5] = exc_in.va[`TLBMR_TAG_VPN_LSB +: 5] & vpn_low_keep;
    // RULE_04: region from top bits
    tag_from_exc[`TLBMR_TAG_R_LSB +: 2] = exc_in.va[`TLBMR_TAG_R_LSB +: 2];
  end

  // RULE_23: modulo-free range fold
  always_comb begin
    case (lfsr_reg[1:0])
      2'h0:    rand_any = 2'h0;
      2'h1:    rand_any = 2'h1;
      2'h2:    rand_any = 2'h2;
      default: rand_any = {1'b0, lfsr_reg[2]};
    endcase
  end
  assign rand_upper = lfsr_reg[3] ? 2'h2 : 2'h1;

  // RULE_14: set 0 kept for pinned entries
  // RULE_16: refill set choice
  assign refill_set = (|wired_hit) ? rand_upper : rand_any;

  // RULE_23: free-running generator
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      lfsr_reg <= `TLBMR_LFSR_SEED;
    end else if (lfsr_reg[0]) begin
      lfsr_reg <= (lfsr_reg >> 1) ^ `TLBMR_LFSR_TAPS;
    end else begin
      lfsr_reg <= lfsr_reg >> 1;
    end
  end

  // Values are cleared only so simulation starts clean
  // RULE_20: no meaningful reset
  // RULE_01: physical entry storage
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      phys_reg <= '0;
    end else if (wr_ok && move_req.num == `TLBMR_REG_PHYS) begin
      // RULE_03: unused bits dropped
      phys_reg <= move_req.wdata & `TLBMR_PHYS_MASK;
    end else if (entry_rd.load) begin
      phys_reg <= entry_rd.phys & `TLBMR_PHYS_MASK;
    end
  end

  // Exception load outranks a software move in the same cycle
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      tag_reg <= '0;
    end else if (exc_xlate) begin
      // RULE_07: identifier kept
      tag_reg <= tag_from_exc & `TLBMR_TAG_MASK;
    end else if (wr_ok && move_req.num == `TLBMR_REG_TAG) begin
      // RULE_09: bits 18 to 12 not held
      tag_reg <= move_req.wdata & `TLBMR_TAG_MASK;
    end else if (entry_rd.load) begin
      tag_reg <= entry_rd.tag & `TLBMR_TAG_MASK;
    end
  end

  // RULE_10: three region bases
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      user_pte_base_reg <= '0;
      kernel_private_pte_base_reg <= '0;
      kernel_global_pte_base_reg <= '0;
    end else if (wr_ok) begin
      if (move_req.num == `TLBMR_REG_USER_PTE_BASE) begin
        user_pte_base_reg <= move_req.wdata & `TLBMR_BASE_MASK;
      end else if (move_req.num == `TLBMR_REG_KERNEL_PRIVATE_PTE_BASE) begin
        kernel_private_pte_base_reg <= move_req.wdata & `TLBMR_BASE_MASK;
      end else if (move_req.num == `TLBMR_REG_KERNEL_GLOBAL_PTE_BASE) begin
        kernel_global_pte_base_reg <= move_req.wdata & `TLBMR_BASE_MASK;
      end
    end
  end

  // RULE_11: loaded only by failed translations
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      shift_reg <= '0;
    end else if (exc_xlate) begin
      shift_reg <= exc_shift;
    end
  end

  // RULE_17: full width address
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      fault_virtual_address_reg <= '0;
    end else if (exc_in.valid) begin
      // RULE_18: faulting address capture
      fault_virtual_address_reg <= exc_in.va;
    end else if (wr_ok && move_req.num == `TLBMR_REG_FAULT_VIRTUAL_ADDRESS) begin
      fault_virtual_address_reg <= move_req.wdata;
    end
  end

  // Pinning more than four entries is not possible by construction
  // RULE_13: four pinned slots
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      wired_reg <= '0;
    end else if (wr_ok && move_req.num == `TLBMR_REG_WIRED) begin
      wired_reg <= move_req.wdata & wired_mask();
    end
  end

  // Set select is also software writable
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      set_reg <= '0;
    end else if (exc_in.valid && exc_in.kind == EXC_REFILL) begin
      // RULE_16: random set on miss
      set_reg <= refill_set;
    end else if (exc_in.valid && (exc_in.kind == EXC_INVALID || exc_in.kind == EXC_MODIFIED)) begin
      // RULE_21: matching set reported
      set_reg <= exc_in.match_set;
    end else if (wr_ok && move_req.num == `TLBMR_REG_SET) begin
      set_reg <= move_req.wdata[1:0];
    end
  end

  function automatic logic [63:0] wired_mask();
    logic [63:0] m;
    m = '0;
    for (int i = 0; i < 4; i++) begin
      m[i*`TLBMR_WIRED_STRIDE +: IDX_W] = '1;
      m[i*`TLBMR_WIRED_STRIDE + `TLBMR_WIRED_VBIT] = 1'b1;
    end
    return m;
  endfunction

  // Unmapped numbers read as zero
  // RULE_03: zero fields on read
  always_comb begin
    rdata_next = '0;
    if (move_req.num == `TLBMR_REG_SET) begin
      rdata_next = {62'h0, set_reg};
    end else if (move_req.num == `TLBMR_REG_PHYS) begin
      rdata_next = phys_reg;
    end else if (move_req.num == `TLBMR_REG_USER_PTE_BASE) begin
      rdata_next = user_pte_base_reg;
    end else if (move_req.num == `TLBMR_REG_SHIFT) begin
      rdata_next = {59'h0, shift_reg} & `TLBMR_SHIFT_MASK;
    end else if (move_req.num == `TLBMR_REG_FAULT_VIRTUAL_ADDRESS) begin
      rdata_next = fault_virtual_address_reg;
    end else if (move_req.num == `TLBMR_REG_TAG) begin
      rdata_next = tag_reg;
    end else if (move_req.num == `TLBMR_REG_KERNEL_PRIVATE_PTE_BASE) begin
      rdata_next = kernel_private_pte_base_reg;
    end else if (move_req.num == `TLBMR_REG_KERNEL_GLOBAL_PTE_BASE) begin
      rdata_next = kernel_global_pte_base_reg;
    end else if (move_req.num == `TLBMR_REG_WIRED) begin
      rdata_next = wired_reg;
    end
  end

  // Narrow reads answer zero rather than a truncated word
  // RULE_22: narrow reads unsupported
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      rdata_reg  <= '0;
      rvalid_reg <= 1'b0;
    end else begin
      rvalid_reg <= move_req.from;
      if (move_req.from) begin
        rdata_reg <= move_req.narrow ? 64'h0000_0000_0000_0000 : rdata_next;
      end
    end
  end

  assign move_rdata        = rdata_reg;
  assign move_rvalid       = rvalid_reg;
  assign phys_entry_out    = phys_reg;
  assign virtual_tag_out   = tag_reg;
  // RULE_08: identifier to the matcher
  assign address_space_id  = tag_reg[`TLBMR_TAG_ADDRESS_SPACE_ID_LSB +: 8];
  // RULE_19: entry addressing
  assign entry_select_addr = fault_virtual_address_reg;
  assign set_select        = set_reg;

  // RULE_02: coherence decode
  always_comb begin
    case (phys_reg[`TLBMR_PHYS_C_LSB +: 3])
      `TLBMR_COH_UNC_PROC: begin
        coh_legal     = 1'b1;
        coh_cacheable = 1'b0;
      end
      `TLBMR_COH_UNC_SEQ: begin
        coh_legal     = 1'b1;
        coh_cacheable = 1'b0;
      end
      `TLBMR_COH_NONCOH, `TLBMR_COH_EXCL, `TLBMR_COH_EXCL_WR: begin
        coh_legal     = 1'b1;
        coh_cacheable = 1'b1;
      end
      default: begin
        coh_legal     = 1'b0;
        coh_cacheable = 1'b0;
      end
    endcase
  end

endmodule // tlbmr_regs
`default_nettype wire

//--- tb/tlbmr_regs_chk.sv
// Port checker for the translation register set
`timescale 1ns/1ps
`default_nettype none
module tlbmr_regs_chk
  import tlbmr_pkg::*;
#(
  parameter int IDX_W = 7
) (
  input wire logic                   clk,
  input wire logic                   nrst,
  input wire tlbmr_pkg::tlbmr_move_s move_req,
  input wire tlbmr_pkg::tlbmr_exc_s  exc_in,
  input wire tlbmr_pkg::tlbmr_rd_s   entry_rd,
  input wire logic [63:0]            move_rdata,
  input wire logic                   move_rvalid,
  input wire logic [63:0]            phys_entry_out,
  input wire logic [63:0]            virtual_tag_out,
  input wire logic [7:0]             address_space_id,
  input wire logic [63:0]            entry_select_addr,
  input wire logic [1:0]             set_select,
  input wire logic                   coh_legal,
  input wire logic                   coh_cacheable
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);
  sequence exc_load;
    exc_in.valid && exc_in.kind != EXC_ADDR_ERR;
  endsequence
  sequence narrow_rd;
    move_req.from && move_req.narrow;
  endsequence
  narrow_read_a: assert property (narrow_rd |=> move_rvalid && move_rdata == 64'h0)
    else $error("narrow read gave data");
  narrow_write_a: assert property (move_req.to && move_req.narrow && !exc_in.valid
    |=> $stable(entry_select_addr))
    else $error("narrow write changed address");
  fault_virtual_address_load_a: assert property (exc_in.valid |=> entry_select_addr == $past(exc_in.va))
    else $error("fault address not loaded");
  tag_load_a: assert property (exc_load |=> virtual_tag_out[63:62] == $past(exc_in.va[63:62])
    && virtual_tag_out[47:24] == $past(exc_in.va[47:24]))
    else $error("tag not loaded from fault");
  zero_force_a: assert property (exc_load ##0 exc_in.psize == PG_16M
    |=> virtual_tag_out[23:19] == 5'h0)
    else $error("page number low bits kept");
  address_space_id_keep_a: assert property (exc_in.valid && !move_req.to && !entry_rd.load
    |=> $stable(address_space_id))
    else $error("identifier changed by fault");
  set_hit_a: assert property (exc_in.valid && exc_in.kind inside {EXC_INVALID, EXC_MODIFIED}
    |=> set_select == $past(exc_in.match_set))
    else $error("matching set not loaded");
  refill_set_a: assert property (exc_in.valid && exc_in.kind == EXC_REFILL
    |=> set_select != 2'h3)
    else $error("refill set out of range");
  fields_zero_a: assert property ((phys_entry_out & 64'hffff_ff00_0000_007f) == 64'h0
    && (virtual_tag_out & 64'h3fff_0000_0007_f00f) == 64'h0)
    else $error("unused bits read nonzero");
  coh_code_a: assert property (coh_legal == !(phys_entry_out[11:9] inside {1, 6, 7})
    && coh_cacheable == (phys_entry_out[11:9] inside {3, 4, 5}))
    else $error("coherence decode wrong");
  address_space_id_view_a: assert property (address_space_id == virtual_tag_out[11:4])
    else $error("identifier output differs");
  read_valid_a: assert property (move_req.from |=> move_rvalid)
    else $error("read gave no valid pulse");
endmodule // tlbmr_regs_chk
`default_nettype wire

//--- tb/tlbmr_pipe_model.sv
// Pipeline and exception side model driving the register set
`timescale 1ns/1ps
`default_nettype none
module tlbmr_pipe_model
  import tlbmr_pkg::*;
(
  input  wire logic                   clk,
  input  wire logic [63:0]            move_rdata,
  output var tlbmr_pkg::tlbmr_move_s  move_req,
  output var tlbmr_pkg::tlbmr_exc_s   exc_in,
  output var tlbmr_pkg::tlbmr_rd_s    entry_rd
);
  initial begin
    move_req = '0;
    exc_in = '0;
    entry_rd = '0;
  end
  // doubleword moves, narrow only on request
  task automatic wr(input logic [4:0] n, input logic [63:0] d, input logic nw = 1'b0);
    @(posedge clk); #1;
    move_req = '{to: 1'b1, from: 1'b0, narrow: nw, num: n, wdata: d};
    @(posedge clk); #1;
    move_req.to = 1'b0;
    // Released data inverted so a stale value cannot pass
    move_req.wdata = ~d;
  endtask
  task automatic rd(input logic [4:0] n, output logic [63:0] q, input logic nw = 1'b0);
    @(posedge clk); #1;
    move_req = '{to: 1'b0, from: 1'b1, narrow: nw, num: n, wdata: ~move_req.wdata};
    @(posedge clk); #1;
    q = move_rdata;
    move_req.from = 1'b0;
  endtask
  // Entry read instruction result, one-cycle load pulse
  task automatic ent(input logic [63:0] p, input logic [63:0] t);
    @(posedge clk); #1;
    entry_rd = '{load: 1'b1, phys: p, tag: t};
    @(posedge clk); #1;
    entry_rd.load = 1'b0;
  endtask
  task automatic exc(input tlbmr_exc_e k, input logic [63:0] va, input tlbmr_psize_e ps,
                     input logic [1:0] ms);
    @(posedge clk); #1;
    exc_in = '{valid: 1'b1, kind: k, va: va, psize: ps, match_set: ms};
    @(posedge clk); #1;
    exc_in.valid = 1'b0;
  endtask
endmodule // tlbmr_pipe_model
`default_nettype wire

//--- tb/tlbmr_regs_tb_top.sv
// Self-checking bench of the translation register set
`timescale 1ns/1ps
`default_nettype none
`include "tlbmr_defines.svh"
module tlbmr_regs_tb_top;
  import tlbmr_pkg::*;
  typedef struct packed {logic [4:0] n; logic [63:0] d; logic [63:0] e;} tlbmr_row_s;
  logic clk, nrst, move_rvalid, coh_legal, coh_cacheable, seen0;
  logic [63:0] move_rdata, phys_entry_out, virtual_tag_out, entry_select_addr, q, q2, va, exp;
  logic [7:0] address_space_id;
  logic [1:0] set_select;
  logic [4:0] sa [7];
  tlbmr_move_s move_req;
  tlbmr_exc_s exc_in;
  tlbmr_rd_s entry_rd;
  tlbmr_row_s rows [8];
  int mismatches, compares;
  tlbmr_regs #(.IDX_W(7)) dut (.clk(clk), .nrst(nrst), .move_req(move_req), .exc_in(exc_in),
    .entry_rd(entry_rd), .move_rdata(move_rdata), .move_rvalid(move_rvalid),
    .phys_entry_out(phys_entry_out), .virtual_tag_out(virtual_tag_out),
    .address_space_id(address_space_id), .entry_select_addr(entry_select_addr),
    .set_select(set_select), .coh_legal(coh_legal), .coh_cacheable(coh_cacheable));
  tlbmr_pipe_model model (.clk(clk), .move_rdata(move_rdata), .move_req(move_req),
    .exc_in(exc_in), .entry_rd(entry_rd));
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  task automatic check(input logic [63:0] seen, input logic [63:0] want);
    compares++;
    if (seen !== want) begin
      mismatches++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, want);
    end
  endtask
  task automatic final_report();
    $display("mismatches %0d compares %0d", mismatches, compares);
    if (mismatches == 0 && compares > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  initial begin
    #(20 * 5000);
    mismatches++;
    final_report();
  end
  initial begin
    nrst = 1'b0;
    sa = '{`TLBMR_SA_4K, `TLBMR_SA_8K, `TLBMR_SA_16K, `TLBMR_SA_64K, `TLBMR_SA_1M,
           `TLBMR_SA_4M, `TLBMR_SA_16M};
    rows = '{'{`TLBMR_REG_PHYS, '1, 64'h0000_00ff_ffff_ff80},
             '{`TLBMR_REG_USER_PTE_BASE, '1, 64'hffff_ffff_ffff_f000},
             '{`TLBMR_REG_KERNEL_PRIVATE_PTE_BASE, 64'h1234_5678_9abc_def0, 64'h1234_5678_9abc_d000},
             '{`TLBMR_REG_KERNEL_GLOBAL_PTE_BASE, 64'h8000_0000_0000_1fff, 64'h8000_0000_0000_1000},
             '{`TLBMR_REG_FAULT_VIRTUAL_ADDRESS, 64'hfedc_ba98_7654_3210, 64'hfedc_ba98_7654_3210},
             '{`TLBMR_REG_TAG, '1, 64'hc000_ffff_fff8_0ff0},
             '{`TLBMR_REG_WIRED, '1, 64'h807f_807f_807f_807f},
             '{5'h1f, '1, 64'h0}};
    repeat (5) @(posedge clk);
    #1 nrst = 1'b1;
    foreach (rows[i]) begin
      model.wr(rows[i].n, rows[i].d);
      model.rd(rows[i].n, q);
      check(q, rows[i].e);
    end
    va = 64'hc000_5555_5aff_f123;
    for (int p = 0; p < 7; p++) begin
      model.exc(EXC_REFILL, va, tlbmr_psize_e'(p), 2'h0);
      exp = va & 64'hc000_ffff_fff8_0000;
      for (int b = 19; b < 24; b++) if (b < sa[p]) exp[b] = 1'b0;
      check(virtual_tag_out & ~64'h0000_0000_0000_0ff0, exp);
      check(address_space_id, 8'hff);
      check(entry_select_addr, va);
      check(set_select == 2'h3, 1'b0);
      model.rd(`TLBMR_REG_SHIFT, q);
      check(q, {59'h0, sa[p]});
    end
    // Only one pinned index valid, distinct classes
    model.wr(`TLBMR_REG_WIRED, 64'h0000_0000_0000_8005);
    seen0 = 1'b0;
    for (int k = 0; k < 16; k++) begin
      model.exc(EXC_REFILL, 64'h0000_0000_0000_5000, PG_4K, 2'h0);
      check(set_select inside {2'h1, 2'h2}, 1'b1);
      model.exc(EXC_REFILL, 64'h0, PG_4K, 2'h0);
      seen0 |= (set_select == 2'h0);
    end
    check(seen0, 1'b1);
    model.exc(EXC_INVALID, va, PG_4K, 2'h2);
    check(set_select, 2'h2);
    model.exc(EXC_MODIFIED, va, PG_4K, 2'h1);
    check(set_select, 2'h1);
    q2 = virtual_tag_out;
    model.exc(EXC_ADDR_ERR, ~va, PG_16M, 2'h0);
    check(entry_select_addr, ~va);
    check(virtual_tag_out, q2);
    model.wr(`TLBMR_REG_FAULT_VIRTUAL_ADDRESS, 64'h0, 1'b1);
    check(entry_select_addr, ~va);
    model.rd(`TLBMR_REG_FAULT_VIRTUAL_ADDRESS, q, 1'b1);
    check(q, 64'h0);
    model.rd(`TLBMR_REG_SHIFT, q);
    model.wr(`TLBMR_REG_SHIFT, ~q);
    model.rd(`TLBMR_REG_SHIFT, q2);
    check(q2, {59'h0, `TLBMR_SA_4K});
    for (int c = 0; c < 8; c++) begin
      model.wr(`TLBMR_REG_PHYS, {52'h0, c[2:0], 9'h080});
      check({coh_legal, coh_cacheable}, {!(c inside {1, 6, 7}), c inside {3, 4, 5}});
    end
    // Entry read result lands masked in both halves
    model.ent('1, '1);
    check(phys_entry_out, 64'h0000_00ff_ffff_ff80);
    check(virtual_tag_out, 64'hc000_ffff_fff8_0ff0);
    // Second reset in mid-run clears state; traffic resumes right after release
    @(posedge clk);
    #1 nrst = 1'b0;
    @(posedge clk);
    #1;
    check(set_select, 2'h0);
    check(coh_legal, 1'b1);
    check(phys_entry_out, 64'h0);
    nrst = 1'b1;
    model.wr(`TLBMR_REG_FAULT_VIRTUAL_ADDRESS, va);
    model.rd(`TLBMR_REG_FAULT_VIRTUAL_ADDRESS, q);
    check(q, va);
    final_report();
  end
endmodule // tlbmr_regs_tb_top
bind tlbmr_regs tlbmr_regs_chk #(.IDX_W(IDX_W)) chk (.clk(clk), .nrst(nrst),
  .move_req(move_req), .exc_in(exc_in), .entry_rd(entry_rd), .move_rdata(move_rdata),
  .move_rvalid(move_rvalid), .phys_entry_out(phys_entry_out),
  .virtual_tag_out(virtual_tag_out), .address_space_id(address_space_id),
  .entry_select_addr(entry_select_addr), .set_select(set_select), .coh_legal(coh_legal),
  .coh_cacheable(coh_cacheable));
`default_nettype wire
